// *** src/drps_pkg.sv ***
// Package with the constants and types shared by the DDR read and precharge sequencer.
package drps_pkg;
    localparam int DATA_W = 32;
    localparam int MASK_W = 4;
    localparam int BANK_W = 2;
    localparam int NUM_BANKS = 4;
    localparam int CMD_W = 3;
    localparam logic [CMD_W-1:0] CMD_NOP = 3'h7;
    localparam logic [CMD_W-1:0] CMD_ACT = 3'h3;
    localparam logic [CMD_W-1:0] CMD_READ = 3'h5;
    localparam logic [CMD_W-1:0] CMD_WRITE = 3'h4;
    localparam logic [CMD_W-1:0] CMD_PRE = 3'h2;
    localparam logic [CMD_W-1:0] CMD_REF = 3'h1;
    localparam logic [CMD_W-1:0] CMD_MRS = 3'h0;
    localparam logic [CMD_W-1:0] CMD_BST = 3'h6;
    localparam int LAT_W = 3;
    localparam logic [LAT_W-1:0] READ_LATENCY_RST = 3'h2;
    localparam int BURST_W = 4;
    localparam logic [BURST_W-1:0] BURST_LEN_RST = 4'h8;
    localparam int SLOT_W = 8;
    localparam logic [DATA_W-1:0] DATA_RST = 32'h0;
    typedef enum logic [1:0] {
        DRPS_IDLE,
        DRPS_READ,
        DRPS_WRITE
    } drps_state_type;
endpackage

// *** src/drps_pipe_if.sv ***
// Interface carrying the read pipeline slots between the sequencer and its delay line.
interface drps_pipe_if;
    import drps_pkg::*;
    logic in_valid;
    logic in_last;
    logic [DATA_W-1:0] in_data;
    logic [LAT_W-1:0] latency;
    logic out_valid;
    logic out_last;
    logic [DATA_W-1:0] out_data;
    modport seq (output in_valid, output in_last, output in_data, output latency,
        input out_valid, input out_last, input out_data);
    modport line (input in_valid, input in_last, input in_data, input latency,
        output out_valid, output out_last, output out_data);
endinterface

// *** src/drps_delay_line.sv ***
// Delay line that holds read words for the programmed read latency.
module drps_delay_line
    import drps_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    drps_pipe_if.line pipe
);
    logic [SLOT_W-1:0] vld_q;
    logic [SLOT_W-1:0] vld_d;
    logic [SLOT_W-1:0] lst_q;
    logic [SLOT_W-1:0] lst_d;
    logic [DATA_W-1:0] dat_q [SLOT_W];
    logic [DATA_W-1:0] dat_d [SLOT_W];

    always_comb begin
        for (int i = 0; i < SLOT_W - 1; i++) begin
            vld_d[i] = vld_q[i+1];
            lst_d[i] = lst_q[i+1];
            dat_d[i] = dat_q[i+1];
        end
        vld_d[SLOT_W-1] = 1'b0;
        lst_d[SLOT_W-1] = 1'b0;
        dat_d[SLOT_W-1] = DATA_RST;
        for (int i = 0; i < SLOT_W; i++) begin
            if (LAT_W'(i) == pipe.latency - LAT_W'(1)) begin
                vld_d[i] = pipe.in_valid;
                lst_d[i] = pipe.in_last;
                dat_d[i] = pipe.in_data;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            vld_q <= '0;
            lst_q <= '0;
            for (int i = 0; i < SLOT_W; i++) begin
                dat_q[i] <= DATA_RST;
            end
        end else begin
            vld_q <= vld_d;
            lst_q <= lst_d;
            dat_q <= dat_d;
        end
    end

    assign pipe.out_valid = vld_q[0];
    assign pipe.out_last = lst_q[0];
    assign pipe.out_data = dat_q[0];
endmodule

// *** src/drps_seq.sv ***
// Top of the DDR device sequencer: read bursts, precharge cut, write masking, drive enable.
// Notes on behaviour
// - A precharge to a bank is accepted while its read burst still runs.
// - Precharge during a read stops data after the word read-latency cycles later.
// - Data drivers go high impedance after the last word of a cut read.
// - Write byte mask affects write data only, never read data.
module drps_seq
    import drps_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [drps_pkg::CMD_W-1:0] cmd,
    input wire logic [drps_pkg::BANK_W-1:0] cmd_bank,
    input wire logic [drps_pkg::LAT_W-1:0] read_latency_cycles,
    input wire logic [drps_pkg::BURST_W-1:0] burst_len,
    input wire logic [drps_pkg::DATA_W-1:0] array_rdata,
    input wire logic [drps_pkg::DATA_W-1:0] dq_in,
    input wire logic [drps_pkg::MASK_W-1:0] write_byte_mask,
    output logic [drps_pkg::DATA_W-1:0] dq_out,
    output logic dq_oe,
    output logic array_we,
    output logic [drps_pkg::MASK_W-1:0] array_wbe,
    output logic [drps_pkg::DATA_W-1:0] array_wdata,
    output logic [drps_pkg::NUM_BANKS-1:0] bank_open
);
    import drps_pkg::*;

    drps_pipe_if pipe ();

    drps_delay_line u_line (
        .sys_clk(sys_clk),
        .rst(rst),
        .pipe(pipe)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Command state.
    drps_state_type state_q;
    drps_state_type state_d;
    logic [BURST_W-1:0] left_q;
    logic [BURST_W-1:0] left_d;
    logic [BANK_W-1:0] bank_q;
    logic [BANK_W-1:0] bank_d;
    logic [NUM_BANKS-1:0] open_q;
    logic [NUM_BANKS-1:0] open_d;
    logic [LAT_W-1:0] lat_q;
    logic [LAT_W-1:0] lat_d;
    logic [BURST_W-1:0] blen_q;
    logic [BURST_W-1:0] blen_d;
    logic rd_valid;
    logic rd_last;
    logic cut;

    always_comb begin
        state_d = state_q;
        left_d = left_q;
        bank_d = bank_q;
        open_d = open_q;
        lat_d = lat_q;
        blen_d = blen_q;
        rd_valid = 1'b0;
        rd_last = 1'b0;
        // A precharge to the reading bank ends issue now; words already queued still drain.
        cut = (state_q == DRPS_READ) && (cmd == CMD_PRE) && (cmd_bank == bank_q);
        case (state_q)
            DRPS_READ: begin
                if (!cut) begin
                    rd_valid = 1'b1;
                    rd_last = (left_q == BURST_W'(1));
                    left_d = left_q - BURST_W'(1);
                    if (left_q == BURST_W'(1)) begin
                        state_d = DRPS_IDLE;
                    end
                end else begin
                    state_d = DRPS_IDLE;
                end
                if (cmd == CMD_BST) begin
                    state_d = DRPS_IDLE;
                end
            end
            DRPS_WRITE: begin
                left_d = left_q - BURST_W'(1);
                if (left_q == BURST_W'(1)) begin
                    state_d = DRPS_IDLE;
                end
            end
            default: begin
            end
        endcase
        if (cmd == CMD_READ && !cut) begin
            state_d = DRPS_READ;
            left_d = burst_len;
            bank_d = cmd_bank;
        end else if (cmd == CMD_WRITE) begin
            state_d = DRPS_WRITE;
            left_d = burst_len;
            bank_d = cmd_bank;
        end
        if (cmd == CMD_ACT) begin
            open_d[cmd_bank] = 1'b1;
        end
        if (cmd == CMD_PRE) begin
            open_d[cmd_bank] = 1'b0;
        end
        if (cmd == CMD_MRS) begin
            lat_d = read_latency_cycles;
            blen_d = burst_len;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_q <= DRPS_IDLE;
            left_q <= '0;
            bank_q <= '0;
            open_q <= '0;
            lat_q <= READ_LATENCY_RST;
            blen_q <= BURST_LEN_RST;
        end else begin
            state_q <= state_d;
            left_q <= left_d;
            bank_q <= bank_d;
            open_q <= open_d;
            lat_q <= lat_d;
            blen_q <= blen_d;
        end
    end

    assign pipe.in_valid = rd_valid;
    assign pipe.in_last = rd_last | cut;
    assign pipe.in_data = array_rdata;
    assign pipe.latency = (lat_q == LAT_W'(0)) ? LAT_W'(1) : lat_q;

    ////////////////////////////////////////////////////////////////////////////
    // Output and write path registers.
    logic [DATA_W-1:0] dq_out_d;
    logic dq_oe_d;
    logic array_we_d;
    logic [MASK_W-1:0] array_wbe_d;
    logic [DATA_W-1:0] array_wdata_d;

    always_comb begin
        dq_out_d = dq_out;
        // Read data leave untouched by the mask; the drivers release after the last word.
        dq_oe_d = pipe.out_valid;
        if (pipe.out_valid) begin
            dq_out_d = pipe.out_data;
        end
        array_we_d = (state_q == DRPS_WRITE);
        array_wbe_d = (state_q == DRPS_WRITE) ? ~write_byte_mask : '0;
        array_wdata_d = dq_in;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            dq_out <= DATA_RST;
            dq_oe <= 1'b0;
            array_we <= 1'b0;
            array_wbe <= '0;
            array_wdata <= DATA_RST;
            bank_open <= '0;
        end else begin
            dq_out <= dq_out_d;
            dq_oe <= dq_oe_d;
            array_we <= array_we_d;
            array_wbe <= array_wbe_d;
            array_wdata <= array_wdata_d;
            bank_open <= open_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    a_cut_ends_burst: assert property (@(posedge sys_clk) disable iff (rst)
        cut |=> state_q == DRPS_IDLE)
        else $error("precharge did not end the read burst");

    a_cut_no_issue: assert property (@(posedge sys_clk) disable iff (rst)
        cut |-> !pipe.in_valid)
        else $error("read word issued in the precharge cycle");

    a_oe_off_after: assert property (@(posedge sys_clk) disable iff (rst)
        pipe.out_valid && pipe.out_last && !pipe.in_valid && lat_q == LAT_W'(1)
        |=> ##1 !dq_oe)
        else $error("drivers still on after last read word");

    a_cut_drv_off: assert property (@(posedge sys_clk) disable iff (rst)
        cut ##1 (cmd != CMD_READ) [*8] |-> !dq_oe)
        else $error("drivers still on after a cut read");

    a_read_mask_free: assert property (@(posedge sys_clk) disable iff (rst)
        state_q != DRPS_WRITE |=> array_wbe == '0 && !array_we)
        else $error("mask reached array outside a write");

    a_read_data: assert property (@(posedge sys_clk) disable iff (rst)
        pipe.out_valid |=> dq_oe && dq_out == $past(pipe.out_data))
        else $error("read word altered on its way out");

    a_write_data: assert property (@(posedge sys_clk) disable iff (rst)
        state_q == DRPS_WRITE |=> array_we && array_wdata == $past(dq_in)
        && array_wbe == ~$past(write_byte_mask))
        else $error("write word or byte enables wrong");

    a_pre_accepted: assert property (@(posedge sys_clk) disable iff (rst)
        cut |=> !bank_open[$past(cmd_bank)])
        else $error("precharge during read not accepted");

    a_oe_follows: assert property (@(posedge sys_clk) disable iff (rst)
        dq_oe |-> $past(pipe.out_valid))
        else $error("drivers on without read data");

    c_cut_read: cover property (@(posedge sys_clk) disable iff (rst) cut);
    c_full_read: cover property (@(posedge sys_clk) disable iff (rst)
        pipe.in_valid && pipe.in_last && !cut);
    c_write: cover property (@(posedge sys_clk) disable iff (rst) array_we);
    c_short_lat: cover property (@(posedge sys_clk) disable iff (rst)
        pipe.out_valid && lat_q == LAT_W'(1));
    c_mode_set: cover property (@(posedge sys_clk) disable iff (rst) cmd == CMD_MRS);
endmodule

// *** verif/drps_ctl_model.sv ***
// Controller model that drives commands and write data into the sequencer.
module drps_ctl_model
    import drps_pkg::*;
#(
    parameter int STABLE_CYC = 40000,
    parameter int PRECH_CYC = 3,
    parameter int MODE_DELAY = 2,
    parameter int LOCK_CYC = 200
) (
    input wire logic sys_clk,
    output logic [drps_pkg::CMD_W-1:0] cmd,
    output logic [drps_pkg::BANK_W-1:0] cmd_bank,
    output logic [drps_pkg::LAT_W-1:0] read_latency_cycles,
    output logic [drps_pkg::BURST_W-1:0] burst_len,
    output logic [drps_pkg::DATA_W-1:0] dq_in,
    output logic [drps_pkg::MASK_W-1:0] write_byte_mask
);
    timeunit 1ns;
    timeprecision 1ps;
    int wait_q [NUM_BANKS];
    initial begin
        cmd = CMD_NOP;
        cmd_bank = 2'h0;
        read_latency_cycles = READ_LATENCY_RST;
        burst_len = BURST_LEN_RST;
        dq_in = 32'h0;
        write_byte_mask = 4'hF;
        foreach (wait_q[b]) wait_q[b] = 0;
    end
    ////////////////////////////////////////////////////////////////////////////
    always @(posedge sys_clk) begin
        foreach (wait_q[b]) if (wait_q[b] > 0) wait_q[b] = wait_q[b] - 1;
    end
    task automatic issue(input logic [CMD_W-1:0] c, input logic [BANK_W-1:0] b);
        @(posedge sys_clk);
        #1;
        cmd = c;
        cmd_bank = b;
        if (c == CMD_PRE) wait_q[b] = PRECH_CYC;
    endtask
    task automatic idle(input int n);
        repeat (n) issue(CMD_NOP, 2'h0);
    endtask
    task automatic activate(input logic [BANK_W-1:0] b);
        for (int k = 0; k < 64 && wait_q[b] != 0; k++) idle(1);
        issue(CMD_ACT, b);
    endtask
    task automatic mode_set(input logic [LAT_W-1:0] lat, input logic [BURST_W-1:0] bl);
        idle(PRECH_CYC);
        @(posedge sys_clk);
        #1;
        read_latency_cycles = lat;
        burst_len = bl;
        cmd = CMD_MRS;
        idle(MODE_DELAY);
    endtask
    task automatic pre_all();
        for (int b = 0; b < NUM_BANKS; b++) issue(CMD_PRE, b[BANK_W-1:0]);
        idle(PRECH_CYC);
    endtask
    task automatic power_up();
        idle(STABLE_CYC);
        pre_all();
        mode_set(READ_LATENCY_RST, BURST_LEN_RST);
        issue(CMD_REF, 2'h0);
        idle(PRECH_CYC);
        issue(CMD_REF, 2'h0);
        idle(PRECH_CYC);
        pre_all();
        mode_set(READ_LATENCY_RST, BURST_LEN_RST);
        idle(LOCK_CYC);
    endtask
    task automatic write_word(input logic [BANK_W-1:0] b, input logic [DATA_W-1:0] d,
        input logic [MASK_W-1:0] m);
        issue(CMD_BST, b);
        issue(CMD_WRITE, b);
        @(posedge sys_clk);
        #1;
        cmd = CMD_NOP;
        dq_in = d;
        write_byte_mask = m;
        @(posedge sys_clk);
        #1;
        dq_in = ~d;
        write_byte_mask = 4'hF;
    endtask
endmodule

// *** verif/tb_top.sv ***
// Self-checking bench for the DDR read and precharge sequencer.
module tb_top
    import drps_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [2:0] lat; logic [3:0] bl; int pre_at; int words;} drps_row_type;
    drps_row_type rows [8] = '{'{3'h2, 4'h4, 0, 4}, '{3'h3, 4'h8, 0, 8}, '{3'h2, 4'h2, 0, 2},
        '{3'h1, 4'h4, 0, 4}, '{3'h2, 4'h8, 5, 4}, '{3'h3, 4'h8, 3, 2}, '{3'h2, 4'h8, 1, 0},
        '{3'h2, 4'h8, 9, 8}};
    logic sys_clk = 1'b0;
    logic rst;
    logic [DATA_W-1:0] array_rdata;
    logic [DATA_W-1:0] wdata_last;
    logic [MASK_W-1:0] wbe_last;
    bit we_first = 1'b1;
    logic [CMD_W-1:0] cmd;
    logic [BANK_W-1:0] cmd_bank;
    logic [LAT_W-1:0] read_latency_cycles;
    logic [BURST_W-1:0] burst_len;
    logic [DATA_W-1:0] dq_in, dq_out, array_wdata, wdata_seen;
    logic [MASK_W-1:0] write_byte_mask, array_wbe, wbe_seen;
    logic dq_oe, array_we;
    logic [NUM_BANKS-1:0] bank_open;
    logic [DATA_W-1:0] got_q [$];
    int error_cnt = 0;
    int total_checks = 0;
    ////////////////////////////////////////////////////////////////////////////
    always #2.5 sys_clk = ~sys_clk;
    initial begin
        array_rdata = 32'h100;
        forever begin
            @(posedge sys_clk);
            #1;
            array_rdata = array_rdata + 32'h1;
        end
    end
    always @(posedge sys_clk) begin
        if (dq_oe === 1'b1) got_q.push_back(dq_out);
        if (array_we === 1'b1 && we_first) begin
            wbe_seen = array_wbe;
            wdata_seen = array_wdata;
        end
        if (array_we === 1'b1) begin
            wbe_last = array_wbe;
            wdata_last = array_wdata;
        end
        we_first = (array_we !== 1'b1);
    end
    drps_ctl_model u_ctl (.sys_clk(sys_clk), .cmd(cmd), .cmd_bank(cmd_bank),
        .read_latency_cycles(read_latency_cycles), .burst_len(burst_len), .dq_in(dq_in),
        .write_byte_mask(write_byte_mask));
    drps_seq u_dut (.sys_clk(sys_clk), .rst(rst), .cmd(cmd), .cmd_bank(cmd_bank),
        .read_latency_cycles(read_latency_cycles), .burst_len(burst_len),
        .array_rdata(array_rdata), .dq_in(dq_in), .write_byte_mask(write_byte_mask),
        .dq_out(dq_out), .dq_oe(dq_oe), .array_we(array_we), .array_wbe(array_wbe),
        .array_wdata(array_wdata), .bank_open(bank_open));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #300000;
        error_cnt++;
        end_of_test();
    end
    initial begin
        logic [BANK_W-1:0] b;
        rst = 1'b1;
        repeat (20) @(posedge sys_clk);
        check({dq_oe, array_we, bank_open}, 32'h0, "reset outputs");
        #1;
        rst = 1'b0;
        u_ctl.power_up();
        foreach (rows[i]) begin
            b = i[BANK_W-1:0];
            u_ctl.mode_set(rows[i].lat, rows[i].bl);
            u_ctl.activate(b);
            u_ctl.idle(2);
            check(bank_open[b], 32'h1, "bank open");
            got_q.delete();
            u_ctl.issue(CMD_READ, b);
            if (rows[i].pre_at > 0) begin
                u_ctl.idle(rows[i].pre_at - 1);
                u_ctl.issue(CMD_PRE, b);
            end
            u_ctl.idle(30);
            check(got_q.size(), rows[i].words, "read word count");
            foreach (got_q[k]) check(got_q[k] - got_q[0], k, "read word order");
            u_ctl.issue(CMD_PRE, b);
            u_ctl.idle(2);
            check(bank_open[b], 32'h0, "bank closed");
        end
        u_ctl.activate(2'h1);
        u_ctl.write_word(2'h1, 32'hA5A55A5A, 4'h5);
        u_ctl.idle(10);
        check(wbe_seen, 32'hA, "write byte enables");
        check(wdata_seen, 32'hA5A55A5A, "write data");
        check(wbe_last, 32'h0, "masked write word");
        check(wdata_last, 32'h5A5AA5A5, "last write data");
        u_ctl.issue(CMD_READ, 2'h1);
        u_ctl.idle(3);
        rst = 1'b1;
        u_ctl.idle(2);
        check({dq_oe, array_we, bank_open}, 32'h0, "mid-run reset");
        rst = 1'b0;
        u_ctl.activate(2'h2);
        u_ctl.idle(2);
        check(bank_open[2'h2], 32'h1, "bank open after reset");
        got_q.delete();
        u_ctl.issue(CMD_READ, 2'h2);
        u_ctl.idle(30);
        check(got_q.size(), 32'h8, "read after reset");
        end_of_test();
    end
endmodule
